// *** rtl/frt_pkg.sv ***
package frt_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CNT_HIGH = 8'h00;
   localparam logic [7:0] ADDR_CNT_LOW = 8'h04;
   localparam logic [7:0] ADDR_ALT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_ALT_LOW = 8'h0C;
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h10;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // Field positions
   localparam int CTRL_ONE_OVF_IE_BIT = 5;
   localparam int CTRL_TWO_CC_LSB = 2;
   localparam int CTRL_TWO_EDGE_BIT = 0;
   localparam int STATUS_OVF_BIT = 5;
   // Reset and special values
   localparam logic [15:0] CNT_RESET = 16'hFFFC;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [1:0] CC_DIV4 = 2'h0;
   localparam logic [1:0] CC_DIV2 = 2'h1;
   localparam logic [1:0] CC_DIV8 = 2'h2;
   localparam logic [1:0] CC_EXT = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Read sequence states
   typedef enum logic [0:0] {
      FRT_SEQ_IDLE = 1'b0,
      FRT_SEQ_HELD = 1'b1
   } frt_seq_t;
   // Control fields
   typedef struct packed {
      logic ovf_ie;
      logic [1:0] clk_sel;
      logic edge_rise;
   } frt_ctrl_t;
endpackage

// *** rtl/frt_timer.sv ***
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen-bit up-counter advances on each selected timer tick, read as two bytes.
// - Primary and alternate views always show the same count.
// - Clock select code 11 takes ticks from the external clock pin.
// - Full wrap takes 131072, 262144 or 524288 CPU cycles.
// - Writing either low byte forces the counter to FFFC.
// - Reset and pulse modes start the count at FFFC, the only load value.
// - High byte read first captures the low byte into a holding buffer.
// - Held low byte stays fixed until the low byte is read.
// - Low byte read outside a sequence returns the live low byte.
// - Rollover FFFF to 0000 sets the overflow flag.
// - Overflow requests interrupt only with enable set and global mask clear.
// - Flag clears after status read with flag set, then primary low access.
// - Alternate low byte accesses never clear the overflow flag.
// - Counter keeps running in wait state.
// - Halt freezes the count; reset wake restarts from reset count.
// - Edge select picks rising or falling external clock transitions.
// - Counter updates are aligned to the CPU clock.
// - Unbonded timer inputs read as one.
module frt_timer #(
   parameter bit EXT_CLK_BONDED = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Timer pins and system state
   input wire logic external_clock_pin_i,
   input wire logic cpu_int_mask_i,
   input wire logic halt_i,
   input wire logic pulse_mode_reload_i,
   output logic ovf_irq_o
);
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0] held_low_reg, held_low_next;
   frt_pkg::frt_seq_t seq_reg, seq_next;
   frt_pkg::frt_ctrl_t ctrl_reg, ctrl_next;
   logic ovf_reg, ovf_next;
   logic ovf_armed_reg, ovf_armed_next;
   logic irq_reg, irq_next;
   logic [2:0] pre_reg, pre_next;
   logic ext_prev_reg, ext_prev_next;
   logic aw_got_reg, aw_got_next;
   logic w_got_reg, w_got_next;
   logic [7:0] waddr_reg, waddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wlane0_reg, wlane0_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic arready_reg, arready_next;
   logic ext_level;
   logic tick;
   logic wr_fire;
   logic rd_fire;
   logic ext_edge;

   // Unbonded pin reads high and so never produces an edge
   assign ext_level = EXT_CLK_BONDED ? external_clock_pin_i : 1'b1;
   assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   assign rd_fire = s_axi_arvalid_i && !rvalid_reg;

   // Prescaler and tick selection
   always_comb begin
      pre_next = pre_reg + 3'h1;
      ext_prev_next = ext_level;
      // Pin is taken synchronous; the source keeps edges seven CPU edges apart
      ext_edge = ctrl_reg.edge_rise ? (ext_level && !ext_prev_reg)
                                    : (!ext_level && ext_prev_reg);
      unique case (ctrl_reg.clk_sel)
         frt_pkg::CC_DIV4: begin
            tick = pre_reg[1:0] == 2'h3;
         end
         frt_pkg::CC_DIV2: begin
            tick = pre_reg[0];
         end
         frt_pkg::CC_DIV8: begin
            tick = pre_reg == 3'h7;
         end
         frt_pkg::CC_EXT: begin
            // Prescaler keeps running so a return to internal clocking is seamless
            tick = ext_edge;
         end
      endcase
      if (halt_i) begin
         tick = 1'b0;
         pre_next = pre_reg;
      end
   end

   // Counter, read buffer and overflow flag
   always_comb begin
      logic hi_rd, lo_rd, lo_acc, st_rd;
      hi_rd = 1'b0;
      lo_rd = 1'b0;
      lo_acc = 1'b0;
      st_rd = 1'b0;
      cnt_next = cnt_reg;
      held_low_next = held_low_reg;
      seq_next = seq_reg;
      ovf_next = ovf_reg;
      ovf_armed_next = ovf_armed_reg;
      if (rd_fire) begin
         hi_rd = s_axi_araddr_i == frt_pkg::ADDR_CNT_HIGH
                 || s_axi_araddr_i == frt_pkg::ADDR_ALT_HIGH;
         lo_rd = s_axi_araddr_i == frt_pkg::ADDR_CNT_LOW
                 || s_axi_araddr_i == frt_pkg::ADDR_ALT_LOW;
         lo_acc = s_axi_araddr_i == frt_pkg::ADDR_CNT_LOW;
         st_rd = s_axi_araddr_i == frt_pkg::ADDR_STATUS;
      end
      if (wr_fire && waddr_reg == frt_pkg::ADDR_CNT_LOW) begin
         lo_acc = 1'b1;
      end
      if (tick) begin
         cnt_next = cnt_reg + 16'h0001;
      end
      if (pulse_mode_reload_i || (wr_fire && wlane0_reg
          && (waddr_reg == frt_pkg::ADDR_CNT_LOW || waddr_reg == frt_pkg::ADDR_ALT_LOW))) begin
         cnt_next = frt_pkg::CNT_RESET;
      end
      if (hi_rd && seq_reg == frt_pkg::FRT_SEQ_IDLE) begin
         held_low_next = cnt_reg[7:0];
         seq_next = frt_pkg::FRT_SEQ_HELD;
      end else if (lo_rd) begin
         seq_next = frt_pkg::FRT_SEQ_IDLE;
      end
      if (st_rd && ovf_reg) begin
         ovf_armed_next = 1'b1;
      end
      if (lo_acc && ovf_armed_reg) begin
         ovf_next = 1'b0;
         ovf_armed_next = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (tick && cnt_reg == frt_pkg::CNT_MAX) begin
         ovf_next = 1'b1;
      end
   end

   // Interrupt request
   always_comb begin
      // Built from the next flag value so the request never lags the flag
      irq_next = ovf_next && ctrl_reg.ovf_ie && !cpu_int_mask_i;
   end

   // AXI4-Lite slave
   always_comb begin
      logic [7:0] raddr;
      raddr = s_axi_araddr_i;
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wlane0_next = wlane0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      ctrl_next = ctrl_reg;
      if (s_axi_awvalid_i && !aw_got_reg) begin
         aw_got_next = 1'b1;
         waddr_next = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_got_reg) begin
         w_got_next = 1'b1;
         wdata_next = s_axi_wdata_i;
         wlane0_next = s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = frt_pkg::RESP_OKAY;
         unique case (waddr_reg)
            frt_pkg::ADDR_CTRL_ONE: begin
               if (wlane0_reg) begin
                  ctrl_next.ovf_ie = wdata_reg[frt_pkg::CTRL_ONE_OVF_IE_BIT];
               end
            end
            frt_pkg::ADDR_CTRL_TWO: begin
               if (wlane0_reg) begin
                  ctrl_next.clk_sel = wdata_reg[frt_pkg::CTRL_TWO_CC_LSB +: 2];
                  ctrl_next.edge_rise = wdata_reg[frt_pkg::CTRL_TWO_EDGE_BIT];
               end
            end
            frt_pkg::ADDR_CNT_LOW, frt_pkg::ADDR_ALT_LOW: begin
            end
            // Counter high bytes and status are read-only
            default: bresp_next = frt_pkg::RESP_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready_i) begin
         bvalid_next = 1'b0;
      end
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rdata_next = 32'h0000_0000;
         rresp_next = frt_pkg::RESP_OKAY;
         unique case (raddr)
            frt_pkg::ADDR_CNT_HIGH, frt_pkg::ADDR_ALT_HIGH: begin
               rdata_next[7:0] = cnt_reg[15:8];
            end
            frt_pkg::ADDR_CNT_LOW, frt_pkg::ADDR_ALT_LOW: begin
               rdata_next[7:0] = (seq_reg == frt_pkg::FRT_SEQ_HELD) ? held_low_reg
                                                                     : cnt_reg[7:0];
            end
            frt_pkg::ADDR_CTRL_ONE: begin
               rdata_next[frt_pkg::CTRL_ONE_OVF_IE_BIT] = ctrl_reg.ovf_ie;
            end
            frt_pkg::ADDR_CTRL_TWO: begin
               rdata_next[frt_pkg::CTRL_TWO_CC_LSB +: 2] = ctrl_reg.clk_sel;
               rdata_next[frt_pkg::CTRL_TWO_EDGE_BIT] = ctrl_reg.edge_rise;
            end
            frt_pkg::ADDR_STATUS: begin
               rdata_next[frt_pkg::STATUS_OVF_BIT] = ovf_reg;
            end
            default: rresp_next = frt_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
      end
      // Ready is offered while the channel's holding slot is empty
      awready_next = !aw_got_next;
      wready_next = !w_got_next;
      arready_next = !rvalid_next;
   end

   // Prescaler and pin history
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_reg <= 3'h0;
         // Idle level of an unbonded pin, so reset leaves no false edge
         ext_prev_reg <= 1'b1;
      end else begin
         pre_reg <= pre_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   // Counter and read buffer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= frt_pkg::CNT_RESET;
         held_low_reg <= 8'h00;
         seq_reg <= frt_pkg::FRT_SEQ_IDLE;
      end else begin
         cnt_reg <= cnt_next;
         held_low_reg <= held_low_next;
         seq_reg <= seq_next;
      end
   end

   // Overflow flag and request
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ovf_reg <= 1'b0;
         ovf_armed_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
         ovf_armed_reg <= ovf_armed_next;
         irq_reg <= irq_next;
      end
   end

   // Write channels and control fields
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= '0;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wlane0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
      end else begin
         ctrl_reg <= ctrl_next;
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wlane0_reg <= wlane0_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
      end
   end

   // Read channels
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
         arready_reg <= 1'b1;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         arready_reg <= arready_next;
      end
   end

   // Every output is a flip-flop, so no bus path runs through gates here
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign ovf_irq_o = irq_reg;
endmodule // frt_timer

// *** testbench/frt_timer_asserts.sv ***
`timescale 1ns/1ps
module frt_timer_asserts #(
   parameter bit EXT_CLK_BONDED = 1'b1
) (
   // Clock and reset
   input logic clk_i,
   input logic rst_b_i,
   // Write channels
   input logic [7:0] s_axi_awaddr_i,
   input logic s_axi_awvalid_i,
   input logic s_axi_awready_o,
   input logic s_axi_wvalid_i,
   input logic s_axi_wready_o,
   input logic [1:0] s_axi_bresp_o,
   input logic s_axi_bvalid_o,
   // Read channels
   input logic [7:0] s_axi_araddr_i,
   input logic s_axi_arvalid_i,
   input logic s_axi_arready_o,
   input logic [31:0] s_axi_rdata_o,
   input logic [1:0] s_axi_rresp_o,
   input logic s_axi_rvalid_o,
   input logic s_axi_rready_i,
   // Interrupt
   input logic cpu_int_mask_i,
   input logic ovf_irq_o
);
   logic [7:0] wa_reg;
   logic [7:0] ra_reg;
   logic wr_ok;
   logic rd_ok;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wa_reg <= 8'h00;
         ra_reg <= 8'h00;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) wa_reg <= s_axi_awaddr_i;
         if (s_axi_arvalid_i && s_axi_arready_o) ra_reg <= s_axi_araddr_i;
      end
   end
   // Only the low views and the control registers take writes
   assign wr_ok = wa_reg inside {8'h04, 8'h0C, 8'h10, 8'h14};
   assign rd_ok = ra_reg <= 8'h18 && ra_reg[1:0] == 2'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_irq_mask; cpu_int_mask_i |=> !ovf_irq_o; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   // With no access in flight nothing may clear the flag
   property p_irq_hold; ovf_irq_o && s_axi_awready_o && s_axi_wready_o && !s_axi_awvalid_i
      && !s_axi_arvalid_i |=> ovf_irq_o || cpu_int_mask_i; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
   property p_rd_lat; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_wr_lat; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer timing");
   property p_wr_resp; $rose(s_axi_bvalid_o) |->
      s_axi_bresp_o == (wr_ok ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR); endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response");
   property p_rd_resp; $rose(s_axi_rvalid_o) |->
      s_axi_rresp_o == (rd_ok ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR); endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response");
   property p_rd_byte; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000; endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("upper data not zero");
   property p_status; s_axi_rvalid_o && ra_reg == frt_pkg::ADDR_STATUS |->
      (s_axi_rdata_o[7:0] & 8'hDF) == 8'h00; endproperty
   a_status: assert property (p_status) else $error("status spare bits");
   c_ovf: cover property (ovf_irq_o);
   c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == frt_pkg::RESP_SLVERR);
   c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // frt_timer_asserts

bind frt_timer frt_timer_asserts #(.EXT_CLK_BONDED(EXT_CLK_BONDED)) u_asserts (.*);

// *** testbench/frt_ext_clk_src.sv ***
`timescale 1ns/1ps
module frt_ext_clk_src #(
   parameter int GAP_CYC = 6
) (
   // CPU clock and pin
   input logic clk_i,
   output logic external_clock_pin_o
);
   initial external_clock_pin_o = 1'b0;
   // Each level is held long enough for the counter to see it twice over
   task automatic drive(input logic lvl);
      @(posedge clk_i);
      external_clock_pin_o <= lvl;
      repeat (GAP_CYC) @(posedge clk_i);
   endtask
endmodule // frt_ext_clk_src

// *** testbench/frt_timer_tb.sv ***
`timescale 1ns/1ps
module frt_timer_tb;
   localparam logic [1:0] OK = frt_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = frt_pkg::RESP_SLVERR;
   logic clk_i, rst_b_i;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   logic external_clock_pin_i, cpu_int_mask_i, halt_i, pulse_mode_reload_i, ovf_irq_o;
   logic [1:0] sel [3] = '{frt_pkg::CC_DIV4, frt_pkg::CC_DIV2, frt_pkg::CC_DIV8};
   int dv [3] = '{4, 2, 8};
   int failures = 0;
   int check_count = 0;
   int n;
   frt_timer dut (.*);
   frt_ext_clk_src u_src (.clk_i(clk_i), .external_clock_pin_o(external_clock_pin_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic guard;
      if (n >= 60) begin
         failures++;
         $display("mismatch at %0t: no answer", $time);
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) break;
      end
      s_axi_bready_i <= 1'b0;
      guard();
      chk(32'(s_axi_bresp_o), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) break;
      end
      s_axi_rready_i <= 1'b0;
      guard();
      chk(32'(s_axi_rresp_o), 32'(er));
      if (er === OK) chk(s_axi_rdata_o, ed);
   endtask
   initial begin
      rst_b_i = 1'b0;
      halt_i = 1'b1;
      s_axi_wstrb_i = 4'hF;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i} = '0;
      {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, cpu_int_mask_i, pulse_mode_reload_i} = '0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // Halted from reset, so the count must still read as the reset value
      rd(8'h00, 32'hFF, OK);
      rd(8'h0C, 32'hFC, OK);
      rd(8'h14, 32'h00, OK);
      rd(8'h1C, 32'h00, ERR);
      wr(8'h08, 32'h00, ERR);
      wr(8'h10, 32'h20, OK);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i) halt_i <= 1'b1;
         wr(8'h14, 32'(sel[i]) << frt_pkg::CTRL_TWO_CC_LSB, OK);
         rd(8'h18, (i > 0) ? 32'h20 : 32'h00, OK);
         wr(8'h04, 32'h00, OK);
         chk(32'(ovf_irq_o), 32'h0);
         @(posedge clk_i) halt_i <= 1'b0;
         for (n = 0; n < 60 && ovf_irq_o !== 1'b1; n++) @(posedge clk_i);
         guard();
         chk(32'(n >= 3 * dv[i] + 1 && n <= 4 * dv[i] + 3), 32'h1);
      end
      @(posedge clk_i) cpu_int_mask_i <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i) chk(32'(ovf_irq_o), 32'h0);
      cpu_int_mask_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(ovf_irq_o), 32'h1);
      @(posedge clk_i) halt_i <= 1'b1;
      wr(8'h14, 32'h0D, OK);
      @(posedge clk_i) pulse_mode_reload_i <= 1'b1;
      @(posedge clk_i) pulse_mode_reload_i <= 1'b0;
      rd(8'h18, 32'h20, OK);
      rd(8'h0C, 32'hFC, OK);
      chk(32'(ovf_irq_o), 32'h1);
      rd(8'h04, 32'hFC, OK);
      chk(32'(ovf_irq_o), 32'h0);
      @(posedge clk_i) halt_i <= 1'b0;
      u_src.drive(1'b1);
      u_src.drive(1'b0);
      u_src.drive(1'b1);
      rd(8'h04, 32'hFE, OK);
      wr(8'h14, 32'h0C, OK);
      u_src.drive(1'b0);
      rd(8'h00, 32'hFF, OK);
      u_src.drive(1'b1);
      u_src.drive(1'b0);
      rd(8'h08, 32'h00, OK);
      chk(32'(ovf_irq_o), 32'h1);
      rd(8'h04, 32'hFF, OK);
      rd(8'h0C, 32'h00, OK);
      @(posedge clk_i) s_axi_wstrb_i <= 4'h0;
      wr(8'h04, 32'h00, OK);
      rd(8'h0C, 32'h00, OK);
      complete_run();
   end
endmodule // frt_timer_tb
